// ---- ncm_pkg.sv ----
// ==========================================================
// Shared constants for the network cycle configuration block
package ncm_pkg;
    localparam int AW = 8;
    localparam int DW = 16;

    // ======================================================
    // Register offsets (byte addresses)
    localparam logic [7:0] ADDR_CTRL_LOOP = 8'h00;
    localparam logic [7:0] ADDR_COMM_CYCLE = 8'h04;
    localparam logic [7:0] ADDR_UPD_RATIO = 8'h08;
    localparam logic [7:0] ADDR_EXT_FUNC = 8'h0C;
    localparam logic [7:0] ADDR_DISP_SEL = 8'h10;
    localparam logic [7:0] ADDR_CONTROL = 8'h14;
    localparam logic [7:0] ADDR_STATUS = 8'h18;
    localparam logic [7:0] ADDR_ACT_MODE = 8'h1C;

    // ======================================================
    // Setting codes
    localparam logic [15:0] LOOP_SEMI = 16'h0000;
    localparam logic [15:0] LOOP_FULL = 16'h0006;
    localparam logic [15:0] CYC_83US = 16'h0000;
    localparam logic [15:0] CYC_166US = 16'h0001;
    localparam logic [15:0] CYC_500US = 16'h0003;
    localparam logic [15:0] CYC_1MS = 16'h0006;
    localparam logic [15:0] RATIO_ONCE = 16'h0001;
    localparam logic [15:0] RATIO_TWICE = 16'h0002;
    localparam logic [15:0] DISP_SEL_NODE = 16'h0004;

    // ======================================================
    // Field positions
    localparam int EXT_SIZE_BIT = 0;
    localparam int EXT_SYNC_BIT = 1;
    localparam int EXT_SCALE_BIT = 4;
    localparam int CTRL_START_BIT = 0;
    localparam int CTRL_STOP_BIT = 1;
    localparam int STAT_PARAM_ERR = 0;
    localparam int STAT_REFUSED = 1;
    localparam int STAT_RUNNING = 2;

    // ======================================================
    // Reset values
    localparam logic [15:0] RST_LOOP = 16'h0000;
    localparam logic [15:0] RST_CYCLE = 16'h0003;
    localparam logic [15:0] RST_RATIO = 16'h0001;
    localparam logic [15:0] RST_EXT = 16'h0000;
    localparam logic [15:0] RST_DISP_SEL = 16'h0000;

    // ======================================================
    // Timing
    localparam int CLK_KHZ = 200000;
    localparam int ADDR_SHOW_MS = 600;
    localparam int ADDR_SHOW_CYC = ADDR_SHOW_MS * CLK_KHZ;
    localparam int ALARM_ALT_MS = 500;
    localparam int ALARM_ALT_CYC = ALARM_ALT_MS * CLK_KHZ;

    // ======================================================
    // Types
    typedef enum logic [3:0] {
        MODE_NONE = 4'h0,
        MODE_PP = 4'h1,
        MODE_CP = 4'h2,
        MODE_CV = 4'h4,
        MODE_CT = 4'h8
    } ncm_mode_t;

    typedef enum logic [1:0] {
        UPD_BAD = 2'h0,
        UPD_166 = 2'h1,
        UPD_500 = 2'h2,
        UPD_1MS = 2'h3
    } ncm_upd_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_RUN = 3'b010,
        ST_FAULT = 3'b100
    } ncm_state_t;
endpackage

// ---- ncm_disp_if.sv ----
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Front panel display signals
interface ncm_disp_if;
    logic [7:0] node_addr;
    logic [15:0] sel;
    logic [7:0] sel_data;
    logic alarm;
    logic [7:0] alarm_main;
    logic [7:0] alarm_sub;
    logic warn;
    logic [7:0] warn_code;
    logic [7:0] digits;
    modport host (output node_addr, sel, sel_data, alarm, alarm_main, alarm_sub, warn,
                  warn_code, input digits);
    modport disp (input node_addr, sel, sel_data, alarm, alarm_main, alarm_sub, warn,
                  warn_code, output digits);
endinterface
`default_nettype wire

// ---- ncm_disp.sv ----
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Front panel display sequencer
module ncm_disp #(
    parameter int P_ADDR_CYC = ncm_pkg::ADDR_SHOW_CYC,
    parameter int P_ALT_CYC = ncm_pkg::ALARM_ALT_CYC
) (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rstn,
    // Display signals
    ncm_disp_if.disp d
);
    import ncm_pkg::*;

    logic [31:0] boot_cnt;
    logic boot_done;
    logic [31:0] alt_cnt;
    logic alt_sub;

    // Node address is held up for a fixed time after power-up
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            boot_cnt <= 32'h0;
            boot_done <= 1'b0;
        end else if (!boot_done) begin
            if (boot_cnt == 32'(P_ADDR_CYC - 1)) begin
                boot_done <= 1'b1;
            end else begin
                boot_cnt <= boot_cnt + 32'h1;
            end
        end
    end

    // Alarm codes alternate main and sub; restarts on main when alarm clears
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            alt_cnt <= 32'h0;
            alt_sub <= 1'b0;
        end else if (!d.alarm) begin
            alt_cnt <= 32'h0;
            alt_sub <= 1'b0;
        end else if (alt_cnt == 32'(P_ALT_CYC - 1)) begin
            alt_cnt <= 32'h0;
            alt_sub <= !alt_sub;
        end else begin
            alt_cnt <= alt_cnt + 32'h1;
        end
    end

    always_comb begin
        if (d.alarm) begin
            d.digits = alt_sub ? d.alarm_sub : d.alarm_main;
        end else if (d.warn) begin
            d.digits = d.warn_code;
        end else if (!boot_done || d.sel == DISP_SEL_NODE) begin
            d.digits = d.node_addr;
        end else begin
            d.digits = d.sel_data;
        end
    end

    chk_warn_show: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        (d.warn && !d.alarm) |-> d.digits == d.warn_code)
        else $error("warning code not shown");
endmodule
`default_nettype wire

// ---- ncm_top.sv ----
// The register offsets and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Full-closed loop allows only profile and cyclic position; velocity, torque refused.
// - Loop setting 0 is semi-closed, 6 full-closed, 1 to 5 reserved.
// - Cycle codes 0,1,3,6 mean 0.0833, 0.1666, 0.5, 1.0 ms; others reserved.
// - Shortest cycle disables encoder pulse regeneration output.
// - Update ratio is 1 or 2; 2 only with 0.0833 or 0.5 ms cycles.
// - Extended bit 0 selects 16-byte or 32-byte frame data.
// - Extended bit 1 selects full sync; zero when timing counter unused.
// - Bit 4 enables scale monitoring under semi-closed; always on under full-closed.
// - Semi-closed scale monitoring forbids cycles of 0.1666 ms or shorter.
// - At 0.5 and 1.0 ms, position modes both loops, velocity and torque semi only.
// - 16-byte fast cycles: cyclic modes semi-closed only, profile position unsupported.
// - 32-byte: nothing at 0.0833 ms; 0.1666 ms only profile at 0.5 ms update (the code accepts no mode at 0.1666 ms).
// - Unsupported cycle and ratio pair raises the parameter combination error.
// - Controller switches modes by command code; device follows valid codes.
// - Display shows node address at power-up, then selected content.
// - Alarm alternates main and sub codes; warning shows warning code.
// - Cyclic position travel is position change across each command update cycle.
module ncm_top #(
    parameter int P_ADDR_CYC = ncm_pkg::ADDR_SHOW_CYC,
    parameter int P_ALT_CYC = ncm_pkg::ALARM_ALT_CYC
) (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rstn,
    // Register port
    input wire logic [ncm_pkg::AW-1:0] i_addr,
    input wire logic [ncm_pkg::DW-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [ncm_pkg::DW-1:0] o_rdata,
    // Link side
    input wire logic i_comm_tick,
    input wire logic i_cmd_valid,
    input wire logic [1:0] i_cmd_code,
    input wire logic [31:0] i_cmd_pos,
    input wire logic i_timing_cnt_used,
    // Panel and status sources
    input wire logic [7:0] i_node_sw,
    input wire logic [7:0] i_sel_data,
    input wire logic i_alarm,
    input wire logic [7:0] i_alarm_main,
    input wire logic [7:0] i_alarm_sub,
    input wire logic i_warn,
    input wire logic [7:0] i_warn_code,
    // Outputs
    output ncm_pkg::ncm_mode_t o_active_mode,
    output logic o_param_err,
    output logic o_running,
    output logic o_pulse_regen_en,
    output logic o_ext_scale_mon,
    output logic o_frame_32byte,
    output logic o_full_sync,
    output logic [31:0] o_travel_cmd,
    output logic o_travel_valid,
    output logic [7:0] o_disp_code
);
    import ncm_pkg::*;

    // ======================================================
    // Decode helpers
    function automatic ncm_upd_t upd_class(input logic [15:0] cyc, input logic [15:0] ratio);
        if (cyc == CYC_83US && ratio == RATIO_TWICE) begin
            upd_class = UPD_166;
        end else if (cyc == CYC_166US && ratio == RATIO_ONCE) begin
            upd_class = UPD_166;
        end else if (cyc == CYC_500US && ratio == RATIO_ONCE) begin
            upd_class = UPD_500;
        end else if (cyc == CYC_500US && ratio == RATIO_TWICE) begin
            upd_class = UPD_1MS;
        end else if (cyc == CYC_1MS && ratio == RATIO_ONCE) begin
            upd_class = UPD_1MS;
        end else begin
            upd_class = UPD_BAD;
        end
    endfunction

    function automatic ncm_mode_t cmd_to_mode(input logic [1:0] code);
        unique case (code)
            2'h0: cmd_to_mode = MODE_PP;
            2'h1: cmd_to_mode = MODE_CP;
            2'h2: cmd_to_mode = MODE_CV;
            2'h3: cmd_to_mode = MODE_CT;
        endcase
    endfunction

    function automatic logic mode_ok(input ncm_mode_t m, input logic [15:0] loop,
                                     input logic [15:0] cyc, input logic [15:0] ratio,
                                     input logic [15:0] ext);
        logic semi;
        logic full;
        logic fast;
        ncm_upd_t u;
        semi = (loop == LOOP_SEMI);
        full = (loop == LOOP_FULL);
        fast = (cyc == CYC_83US) || (cyc == CYC_166US);
        u = upd_class(cyc, ratio);
        if (m == MODE_NONE || u == UPD_BAD || !(semi || full)) begin
            mode_ok = 1'b0;
        end else if (full && (m == MODE_CV || m == MODE_CT)) begin
            mode_ok = 1'b0;
        end else if (semi && ext[EXT_SCALE_BIT] && fast) begin
            mode_ok = 1'b0;
        end else if (fast && !ext[EXT_SIZE_BIT]) begin
            mode_ok = semi && u == UPD_166 && m != MODE_PP;
        end else if (fast) begin
            mode_ok = cyc == CYC_166US && u == UPD_500 && m == MODE_PP;
        end else begin
            mode_ok = (m == MODE_PP) || (m == MODE_CP) || semi;
        end
    endfunction

    // ======================================================
    // Registers
    logic [15:0] cfg_loop;
    logic [15:0] cfg_cycle;
    logic [15:0] cfg_ratio;
    logic [15:0] cfg_ext;
    logic [15:0] disp_sel;
    logic [15:0] act_loop;
    logic [15:0] act_cycle;
    logic [15:0] act_ratio;
    logic [15:0] act_ext;
    logic param_err;
    logic refused;
    ncm_state_t state;
    logic wr_ctrl;
    logic start_req;
    logic stop_req;
    logic clr_param;
    logic clr_refused;
    logic cmd_take;
    logic cmd_good;
    ncm_mode_t cmd_mode;

    assign wr_ctrl = i_wr && i_addr == ADDR_CONTROL;
    assign start_req = wr_ctrl && i_wdata[CTRL_START_BIT];
    assign stop_req = wr_ctrl && i_wdata[CTRL_STOP_BIT];
    assign clr_param = i_wr && i_addr == ADDR_STATUS && i_wdata[STAT_PARAM_ERR];
    assign clr_refused = i_wr && i_addr == ADDR_STATUS && i_wdata[STAT_REFUSED];
    assign cmd_mode = cmd_to_mode(i_cmd_code);
    assign cmd_take = state == ST_RUN && i_cmd_valid;
    assign cmd_good = mode_ok(cmd_mode, act_loop, act_cycle, act_ratio, act_ext);

    // Bits 2 and 3 of the extended setting are stored as written
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            cfg_loop <= RST_LOOP;
            cfg_cycle <= RST_CYCLE;
            cfg_ratio <= RST_RATIO;
            cfg_ext <= RST_EXT;
            disp_sel <= RST_DISP_SEL;
        end else if (i_wr) begin
            if (i_addr == ADDR_CTRL_LOOP) begin
                cfg_loop <= i_wdata;
            end
            if (i_addr == ADDR_COMM_CYCLE) begin
                cfg_cycle <= i_wdata;
            end
            if (i_addr == ADDR_UPD_RATIO) begin
                cfg_ratio <= i_wdata;
            end
            if (i_addr == ADDR_EXT_FUNC) begin
                cfg_ext <= i_wdata;
            end
            if (i_addr == ADDR_DISP_SEL) begin
                disp_sel <= i_wdata;
            end
        end
    end

    // ======================================================
    // Configuration state: settings frozen while running
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            state <= ST_IDLE;
            act_loop <= RST_LOOP;
            act_cycle <= RST_CYCLE;
            act_ratio <= RST_RATIO;
            act_ext <= RST_EXT;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    if (start_req) begin
                        act_loop <= cfg_loop;
                        act_cycle <= cfg_cycle;
                        act_ratio <= cfg_ratio;
                        act_ext <= cfg_ext;
                        if (upd_class(cfg_cycle, cfg_ratio) == UPD_BAD) begin
                            state <= ST_FAULT;
                        end else begin
                            state <= ST_RUN;
                        end
                    end
                end
                ST_RUN, ST_FAULT: begin
                    if (stop_req) begin
                        state <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // Sticky flags: a new event in the clearing cycle wins
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            param_err <= 1'b0;
        end else if (state == ST_IDLE && start_req &&
                     upd_class(cfg_cycle, cfg_ratio) == UPD_BAD) begin
            param_err <= 1'b1;
        end else if (clr_param) begin
            param_err <= 1'b0;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            refused <= 1'b0;
        end else if (cmd_take && !cmd_good) begin
            refused <= 1'b1;
        end else if (clr_refused) begin
            refused <= 1'b0;
        end
    end

    // ======================================================
    // Operation mode follows the controller's command code
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_active_mode <= MODE_NONE;
        end else if (state != ST_RUN) begin
            o_active_mode <= MODE_NONE;
        end else if (cmd_take && cmd_good) begin
            o_active_mode <= cmd_mode;
        end
    end

    // ======================================================
    // Cyclic position travel per command update cycle
    logic [1:0] upd_cnt;
    logic [31:0] last_pos;
    logic upd_edge;
    assign upd_edge = (2'(upd_cnt + 2'h1) == act_ratio[1:0]);

    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            upd_cnt <= 2'h0;
            last_pos <= 32'h0;
            o_travel_cmd <= 32'h0;
            o_travel_valid <= 1'b0;
        end else begin
            o_travel_valid <= 1'b0;
            if (state != ST_RUN || o_active_mode != MODE_CP) begin
                upd_cnt <= 2'h0;
                if (i_comm_tick) begin
                    last_pos <= i_cmd_pos;
                end
            end else if (i_comm_tick) begin
                if (upd_edge) begin
                    upd_cnt <= 2'h0;
                    last_pos <= i_cmd_pos;
                    o_travel_cmd <= i_cmd_pos - last_pos;
                    o_travel_valid <= 1'b1;
                end else begin
                    upd_cnt <= 2'(upd_cnt + 2'h1);
                end
            end
        end
    end

    // ======================================================
    // Function outputs
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_param_err <= 1'b0;
            o_running <= 1'b0;
            o_pulse_regen_en <= 1'b0;
            o_ext_scale_mon <= 1'b0;
            o_frame_32byte <= 1'b0;
            o_full_sync <= 1'b0;
        end else begin
            o_param_err <= param_err;
            o_running <= state == ST_RUN;
            o_pulse_regen_en <= state == ST_RUN && act_cycle != CYC_83US;
            o_ext_scale_mon <= state == ST_RUN &&
                (act_loop == LOOP_FULL || act_ext[EXT_SCALE_BIT]);
            o_frame_32byte <= state == ST_RUN && act_ext[EXT_SIZE_BIT];
            // Sync bit is ignored without a timing counter
            o_full_sync <= state == ST_RUN && act_ext[EXT_SYNC_BIT] &&
                i_timing_cnt_used;
        end
    end

    // ======================================================
    // Read data, one cycle after the strobe; unmapped reads zero
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_rdata <= 16'h0000;
        end else if (i_rd) begin
            unique case (i_addr)
                ADDR_CTRL_LOOP: o_rdata <= cfg_loop;
                ADDR_COMM_CYCLE: o_rdata <= cfg_cycle;
                ADDR_UPD_RATIO: o_rdata <= cfg_ratio;
                ADDR_EXT_FUNC: o_rdata <= cfg_ext;
                ADDR_DISP_SEL: o_rdata <= disp_sel;
                ADDR_STATUS: o_rdata <= {13'h0000, state == ST_RUN, refused, param_err};
                ADDR_ACT_MODE: o_rdata <= {12'h000, o_active_mode};
                default: o_rdata <= 16'h0000;
            endcase
        end else begin
            o_rdata <= 16'h0000;
        end
    end

    // ======================================================
    // Front panel
    logic [7:0] node_addr;
    logic node_cap;
    ncm_disp_if disp_bus ();

    // Switch is read once after reset; later changes are ignored
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            node_addr <= 8'h00;
            node_cap <= 1'b0;
        end else if (!node_cap) begin
            node_addr <= i_node_sw;
            node_cap <= 1'b1;
        end
    end

    assign disp_bus.node_addr = node_addr;
    assign disp_bus.sel = disp_sel;
    assign disp_bus.sel_data = i_sel_data;
    assign disp_bus.alarm = i_alarm;
    assign disp_bus.alarm_main = i_alarm_main;
    assign disp_bus.alarm_sub = i_alarm_sub;
    assign disp_bus.warn = i_warn;
    assign disp_bus.warn_code = i_warn_code;

    ncm_disp #(.P_ADDR_CYC(P_ADDR_CYC), .P_ALT_CYC(P_ALT_CYC)) u_disp (
        .i_ref_clk(i_ref_clk),
        .i_rstn(i_rstn),
        .d(disp_bus.disp)
    );

    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_disp_code <= 8'h00;
        end else begin
            o_disp_code <= disp_bus.digits;
        end
    end

    // ======================================================
    // Checks
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rstn);

    chk_full_loop_modes: assert property (
        (state == ST_RUN && act_loop == LOOP_FULL) |->
        !(o_active_mode inside {MODE_CV, MODE_CT}))
        else $error("velocity or torque active under full-closed loop");
    chk_regen_fast_cycle: assert property (
        o_pulse_regen_en |-> $past(state == ST_RUN && act_cycle != CYC_83US))
        else $error("pulse regeneration on at shortest cycle");
    chk_ratio_error: assert property (
        (state == ST_IDLE && start_req && upd_class(cfg_cycle, cfg_ratio) == UPD_BAD)
        |=> state == ST_FAULT ##1 o_param_err)
        else $error("bad cycle and ratio did not raise error");
    chk_hold_config: assert property (
        (state == ST_RUN && $past(state) == ST_RUN) |->
        ($stable(act_cycle) && $stable(act_ratio) && $stable(act_ext)))
        else $error("settings changed while running");
    chk_refuse_mode: assert property (
        (cmd_take && !cmd_good) |=> ($stable(o_active_mode) && refused))
        else $error("unsupported mode was taken");
    chk_follow_cmd: assert property (
        (cmd_take && cmd_good && !stop_req) |=> o_active_mode == $past(cmd_mode))
        else $error("valid command code not followed");
    chk_frame_size: assert property (
        o_frame_32byte |-> $past(act_ext[EXT_SIZE_BIT] && state == ST_RUN))
        else $error("32-byte mode without size bit");
    chk_scale_full: assert property (
        (state == ST_RUN && act_loop == LOOP_FULL) |=> o_ext_scale_mon || state != ST_RUN)
        else $error("scale monitor off under full-closed loop");
    chk_travel_cp: assert property (
        o_travel_valid |-> ($past(o_active_mode) == MODE_CP && $past(i_comm_tick)))
        else $error("travel issued outside cyclic position tick");
    chk_sync_bit: assert property (
        o_full_sync |-> $past(i_timing_cnt_used))
        else $error("full sync without timing counter");
endmodule
`default_nettype wire

// ---- ncm_ctrl_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Upper controller: cycle ticks, position ramp, command codes
module ncm_ctrl_model #(
    parameter int P_TICK = 10
) (
    input wire logic i_ref_clk,
    input wire logic i_rstn,
    output logic o_tick,
    output logic o_cmd_valid = 1'b0,
    output logic [1:0] o_cmd_code = 2'h0,
    output logic [31:0] o_cmd_pos
);
    int cnt;
    // Tick period fixed at P_TICK clocks, whatever cycle the bench programs into the block
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            cnt <= 0;
            o_tick <= 1'b0;
            o_cmd_pos <= 32'h0;
        end else begin
            cnt <= (cnt == P_TICK - 1) ? 0 : cnt + 1;
            o_tick <= (cnt == P_TICK - 1);
            if (cnt == P_TICK - 1) begin
                o_cmd_pos <= o_cmd_pos + 32'h10;
            end
        end
    end
    // Code is scrambled after the pulse so a stale value never passes
    task automatic send(input logic [1:0] c);
        @(posedge i_ref_clk);
        o_cmd_valid <= 1'b1;
        o_cmd_code <= c;
        @(posedge i_ref_clk);
        o_cmd_valid <= 1'b0;
        o_cmd_code <= ~c;
    endtask
endmodule
`default_nettype wire

// ---- test_network_cycle_mode_config.sv ----
`timescale 1ns/1ps
`default_nettype none
module test_network_cycle_mode_config;
    import ncm_pkg::*;
    logic clk = 0, rstn = 0, wr = 0, rd = 0, al = 0, tk, cv, tv, pe, run, rg, sc, f32, fs;
    logic [7:0] a = 8'h0, am = 8'h0, as = 8'h0, dsp;
    logic [15:0] wd = 16'h0, rdat;
    logic tcu = 0, wn = 0;
    logic [7:0] sd = 8'hC3, wc = 8'h00;
    logic [1:0] cc;
    logic [31:0] cp, trav;
    ncm_mode_t md;
    int errors = 0, comparisons = 0, i;
    ncm_ctrl_model i_ctrl (.i_ref_clk(clk), .i_rstn(rstn), .o_tick(tk), .o_cmd_valid(cv),
        .o_cmd_code(cc), .o_cmd_pos(cp));
    ncm_top #(.P_ADDR_CYC(20), .P_ALT_CYC(8)) i_dut (.i_ref_clk(clk), .i_rstn(rstn),
        .i_addr(a), .i_wdata(wd), .i_wr(wr), .i_rd(rd), .o_rdata(rdat), .i_comm_tick(tk),
        .i_cmd_valid(cv), .i_cmd_code(cc), .i_cmd_pos(cp), .i_timing_cnt_used(tcu),
        .i_node_sw(8'h5A), .i_sel_data(sd), .i_alarm(al), .i_alarm_main(am),
        .i_alarm_sub(as), .i_warn(wn), .i_warn_code(wc), .o_active_mode(md),
        .o_param_err(pe), .o_running(run), .o_pulse_regen_en(rg), .o_ext_scale_mon(sc),
        .o_frame_32byte(f32), .o_full_sync(fs), .o_travel_cmd(trav),
        .o_travel_valid(tv), .o_disp_code(dsp));
    initial begin
        forever #2.5 clk = ~clk;
    end
    task automatic cmp(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e) begin
            errors++;
            $display("MISMATCH %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic w(input logic [7:0] ad, input logic [15:0] d);
        @(posedge clk);
        wr <= 1'b1;
        a <= ad;
        wd <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic r(input logic [7:0] ad, input logic [15:0] e);
        @(posedge clk);
        rd <= 1'b1;
        a <= ad;
        @(posedge clk);
        rd <= 1'b0;
        #1 cmp(rdat, e);
    endtask
    // Start, then let the capture settle; stop and clear sticky flags
    task automatic go(input logic [15:0] ext);
        w(ADDR_EXT_FUNC, ext);
        w(ADDR_CONTROL, 16'h0001);
        repeat (3) @(posedge clk);
        #1;
    endtask
    task automatic halt();
        w(ADDR_CONTROL, 16'h0002);
        w(ADDR_STATUS, 16'h0003);
    endtask
    task automatic close_out();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        #100000;
        errors++;
        close_out();
    end
    initial begin
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        tcu <= 1'b1;
        repeat (4) @(posedge clk);
        #1 cmp(dsp, 8'h5A);
        r(ADDR_CTRL_LOOP, RST_LOOP);
        r(ADDR_COMM_CYCLE, RST_CYCLE);
        r(ADDR_UPD_RATIO, RST_RATIO);
        r(8'h20, 16'h0000);
        $display("test reset done");
        w(ADDR_COMM_CYCLE, CYC_166US);
        w(ADDR_UPD_RATIO, RATIO_TWICE);
        go(16'h0000);
        cmp(run, 1'b0);
        r(ADDR_STATUS, 16'h0001);
        cmp(pe, 1'b1);
        halt();
        $display("test bad ratio done");
        w(ADDR_CTRL_LOOP, LOOP_FULL);
        w(ADDR_COMM_CYCLE, CYC_500US);
        go(16'h0002);
        cmp(sc, 1'b1);
        cmp(fs, 1'b1);
        cmp(rg, 1'b1);
        cmp(run, 1'b1);
        i_ctrl.send(2'd2);
        r(ADDR_STATUS, 16'h0006);
        cmp(md, MODE_NONE);
        i_ctrl.send(2'd1);
        #6 cmp(md, MODE_CP);
        i = 0;
        while (tv !== 1'b1 && i < 60) begin
            @(negedge clk);
            i++;
        end
        cmp(trav, 32'h20);
        halt();
        $display("test full closed done");
        w(ADDR_CTRL_LOOP, LOOP_SEMI);
        w(ADDR_COMM_CYCLE, CYC_83US);
        go(16'h0000);
        cmp(rg, 1'b0);
        cmp(fs, 1'b0);
        i_ctrl.send(2'd0);
        i_ctrl.send(2'd3);
        #6 cmp(md, MODE_CT);
        r(ADDR_STATUS, 16'h0006);
        halt();
        go(16'h0001);
        cmp(f32, 1'b1);
        i_ctrl.send(2'd1);
        #6 cmp(md, MODE_NONE);
        halt();
        go(16'h0010);
        cmp(sc, 1'b1);
        i_ctrl.send(2'd1);
        #6 cmp(md, MODE_NONE);
        $display("test fast cycle done");
        @(posedge clk);
        am <= 8'h31;
        as <= 8'h07;
        al <= 1'b1;
        wn <= 1'b1;
        wc <= 8'h4B;
        repeat (3) @(posedge clk);
        #1 cmp(dsp, 8'h31);
        repeat (8) @(posedge clk);
        #1 cmp(dsp, 8'h07);
        $display("test alarm done");
        @(posedge clk);
        al <= 1'b0;
        repeat (2) @(posedge clk);
        #1 cmp(dsp, 8'h4B);
        @(posedge clk);
        wn <= 1'b0;
        repeat (2) @(posedge clk);
        #1 cmp(dsp, 8'hC3);
        w(ADDR_DISP_SEL, DISP_SEL_NODE);
        repeat (2) @(posedge clk);
        #1 cmp(dsp, 8'h5A);
        $display("test display done");
        close_out();
    end
endmodule
`default_nettype wire
